// [rtl/dpct_cfg.svh]
// Offsets, encodings and timing constants of the bring-up sequencer
`ifndef DPCT_CFG_SVH
`define DPCT_CFG_SVH
// Software register byte addresses
`define DPCT_SW_CTRL      8'h00
`define DPCT_SW_CFG       8'h04
`define DPCT_SW_SPD       8'h08
`define DPCT_SW_LAT       8'h0C
`define DPCT_SW_RCV       8'h10
`define DPCT_SW_WRD       8'h14
`define DPCT_SW_STAT      8'h18
`define DPCT_SW_TURN      8'h1C
// Device register byte addresses
`define DPCT_DEV_MODE     8'h00
`define DPCT_DEV_COMP     8'h04
`define DPCT_DEV_PD       8'h08
`define DPCT_DEV_TIM      8'h0C
`define DPCT_DEV_TURN     8'h10
// Module type byte encodings
`define DPCT_SPD_DDR2     8'h08
`define DPCT_SPD_DDR3     8'h0B
// Memory clock codes
`define DPCT_FREQ_400     3'h2
// Compensation stop wait
`define DPCT_CLK_MHZ      100
`define DPCT_COMP_WAIT_NS 5000
`define DPCT_COMP_CYC     ((`DPCT_COMP_WAIT_NS * `DPCT_CLK_MHZ + 999) / 1000)
// Turnaround arithmetic
`define DPCT_TURN_ADD     9'sh003
`define DPCT_TURN_MAX     4'hF
`define DPCT_DDR2_LD      7'sh01
// Predriver code for each normalized drive strength
`define DPCT_PD_0         3'h1
`define DPCT_PD_1         3'h3
`define DPCT_PD_2         3'h5
`define DPCT_PD_3         3'h7
`define DPCT_PD_ZERO      3'h0
// Zero values for clearing the read data and the wait counter
`define DPCT_W32_ZERO     32'h0000_0000
`define DPCT_CNT_ZERO     16'h0000
`endif

// [rtl/dpct_pkg.sv]
// Types of the bring-up sequencer: states, carriers, register layouts
package dpct_pkg;
	typedef enum logic [3:0] {
		DPCT_IDLE, DPCT_MODE, DPCT_COMP_OFF, DPCT_COMP_WAIT,
		DPCT_PREDRV, DPCT_TIMING, DPCT_TURN_MAX, DPCT_TRAIN_WAIT,
		DPCT_TURN_OPT, DPCT_COMP_ON
	} dpct_state_e;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} dpct_sw_req_s;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
	} dpct_dev_req_s;
	typedef struct packed {
		logic [29:0] rsv;
		logic        train_done;
		logic        start;
	} dpct_sw_ctrl_s;
	typedef struct packed {
		logic [23:0] rsv;
		logic        gang4_533;
		logic [1:0]  data_drive_strength;
		logic [1:0]  addr_cmd_drive_strength;
		logic [2:0]  target_freq;
	} dpct_sw_cfg_s;
	typedef struct packed {
		logic [20:0] rsv;
		logic [2:0]  freq_limit;
		logic [7:0]  mem_type;
	} dpct_sw_spd_s;
	typedef struct packed {
		logic [21:0] rsv;
		logic [4:0]  write_cas;
		logic [4:0]  read_cas;
	} dpct_lat_s;
	typedef struct packed {
		logic [21:0] rsv;
		logic        ddr3;
		logic        type_bad;
		logic        done;
		logic        train_wait;
		logic        busy;
		logic        pass;
		logic [3:0]  state;
	} dpct_sw_stat_s;
	typedef struct packed {
		logic [26:0] rsv;
		logic [2:0]  memory_clock;
		logic        ddr3_type_select;
		logic        legacy_route_select;
	} dpct_dev_mode_s;
	typedef struct packed {
		logic [30:0] rsv;
		logic        auto_comp_disable;
	} dpct_dev_comp_s;
	typedef struct packed {
		logic [13:0] rsv;
		logic [2:0]  data_b_p_predriver_code;
		logic [2:0]  data_b_n_predriver_code;
		logic [2:0]  data_a_p_predriver_code;
		logic [2:0]  data_a_n_predriver_code;
		logic [2:0]  addr_cmd_p_predriver_code;
		logic [2:0]  addr_cmd_n_predriver_code;
	} dpct_dev_pd_s;
	typedef struct packed {
		logic [15:0] rsv;
		logic [3:0]  read_write_turnaround;
		logic [3:0]  write_read_turnaround;
		logic [3:0]  write_write_turnaround;
		logic [3:0]  read_read_turnaround;
	} dpct_turn_s;
endpackage

// [rtl/dpct_host.sv]
// Bring-up sequencer that programs the memory controller and its phy
`timescale 1ns/1ns
`include "dpct_cfg.svh"

module dpct_host #(
	parameter int NMOD = 4,
	parameter int DW   = 4
) (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	// Software register port
	input  wire dpct_pkg::dpct_sw_req_s sw_req,
	output logic [31:0]                 sw_rdata,
	// Device register port
	output dpct_pkg::dpct_dev_req_s     dev_req
);
	import dpct_pkg::*;

	initial begin
		if (NMOD < 2 || NMOD * DW > 32 || DW < 1 || DW > 8)
			$error("dpct_host: unsupported NMOD or DW");
		// The wait counter is 16 bits wide
		if (`DPCT_COMP_CYC < 1 || `DPCT_COMP_CYC > 16'hFFFF)
			$error("dpct_host: compensation wait does not fit the counter");
	end

	typedef struct packed {
		dpct_state_e          st;
		logic                 pass;
		logic                 two_pass;
		logic                 ddr3;
		logic                 busy;
		logic                 train_wait;
		logic                 done;
		logic                 type_bad;
		logic [2:0]           freq;
		dpct_sw_cfg_s         cfg;
		dpct_sw_spd_s         spd;
		dpct_lat_s            lat;
		logic [NMOD*DW-1:0]   rcv;
		logic [NMOD*DW-1:0]   wrd;
		logic [15:0]          wcnt;
		dpct_turn_s           turn;
		logic [31:0]          rdata;
		dpct_dev_req_s        dev;
	} dpct_reg_s;

	localparam logic [15:0] COMP_LAST = 16'(`DPCT_COMP_CYC - 1);

	dpct_reg_s r_r;
	dpct_reg_s r_nxt;

	// Largest coarse delay over all modules
	function automatic logic [DW-1:0] max_of(input logic [NMOD*DW-1:0] v);
		logic [DW-1:0] m;
		m = v[DW-1:0];
		for (int i = 1; i < NMOD; i++) begin
			if (v[i*DW +: DW] > m)
				m = v[i*DW +: DW];
		end
		return m;
	endfunction

	// Smallest coarse delay over all modules
	function automatic logic [DW-1:0] min_of(input logic [NMOD*DW-1:0] v);
		logic [DW-1:0] m;
		m = v[DW-1:0];
		for (int i = 1; i < NMOD; i++) begin
			if (v[i*DW +: DW] < m)
				m = v[i*DW +: DW];
		end
		return m;
	endfunction

	// Largest delay of one kind minus smallest of the same or the other kind, never negative
	function automatic logic [DW-1:0] crit_diff(input logic [DW-1:0] hi,
			input logic [DW-1:0] lo);
		return (hi > lo) ? DW'(hi - lo) : '0;
	endfunction

	// Half difference rounded down, plus latency term, plus fixed gap
	function automatic logic [3:0] turn_calc(input logic [DW-1:0] critical_coarse_delay_diff,
			input logic signed [6:0] ld);
		logic signed [8:0] v;
		v = $signed(9'(critical_coarse_delay_diff >> 1)) + 9'(ld) + `DPCT_TURN_ADD;
		if (v < 0)
			return '0;
		else if (v > $signed(9'(`DPCT_TURN_MAX)))
			return `DPCT_TURN_MAX;
		else
			return 4'(v);
	endfunction

	// Table is fixed; a board with other pads needs new codes here
	function automatic logic [2:0] pd_code(input logic [1:0] strength);
		case (strength)
			2'h0:    return `DPCT_PD_0;
			2'h1:    return `DPCT_PD_1;
			2'h2:    return `DPCT_PD_2;
			default: return `DPCT_PD_3;
		endcase
	endfunction

	// One device write; the strobe drops again on the following cycle unless the next state writes too
	function automatic dpct_dev_req_s dev_write(input logic [7:0] a,
			input logic [31:0] d);
		dpct_dev_req_s q;
		q.addr  = a;
		q.wdata = d;
		q.wr    = 1'b1;
		return q;
	endfunction

	dpct_sw_ctrl_s     ctrl_w;
	dpct_dev_mode_s    mode_w;
	dpct_dev_comp_s    comp_w;
	dpct_dev_pd_s      pd_w;
	dpct_lat_s         tim_w;
	dpct_turn_s        turn_w;
	dpct_sw_stat_s     stat_w;
	logic signed [6:0] ld;
	logic [DW-1:0]     rcv_max;
	logic [DW-1:0]     rcv_min;
	logic [DW-1:0]     wrd_max;
	logic [DW-1:0]     wrd_min;
	logic              is_ddr2;
	logic              is_ddr3;
	logic [2:0]        freq_sel;

	always_comb begin
		r_nxt = r_r;
		r_nxt.dev.wr = 1'b0;
		ctrl_w = dpct_sw_ctrl_s'(sw_req.wdata);
		if (!(sw_req.wr && sw_req.addr == `DPCT_SW_CTRL))
			ctrl_w = '0;

		is_ddr2 = r_r.spd.mem_type == `DPCT_SPD_DDR2;
		is_ddr3 = r_r.spd.mem_type == `DPCT_SPD_DDR3;
		// Slower of requested clock and the module's cycle-time limit
		freq_sel = (r_r.cfg.target_freq < r_r.spd.freq_limit) ?
			r_r.cfg.target_freq : r_r.spd.freq_limit;

		// Latency difference, signed for DDR3
		if (r_r.ddr3)
			ld = $signed({2'h0, r_r.lat.read_cas}) -
				$signed({2'h0, r_r.lat.write_cas});
		else
			ld = `DPCT_DDR2_LD;

		rcv_max = max_of(r_r.rcv);
		rcv_min = min_of(r_r.rcv);
		wrd_max = max_of(r_r.wrd);
		wrd_min = min_of(r_r.wrd);

		mode_w = '0;
		mode_w.legacy_route_select = 1'b0;
		mode_w.ddr3_type_select = r_r.ddr3;
		mode_w.memory_clock = (r_r.two_pass && !r_r.pass) ?
			`DPCT_FREQ_400 : r_r.freq;

		comp_w = '0;

		pd_w = '0;
		pd_w.addr_cmd_n_predriver_code =
			pd_code(r_r.cfg.addr_cmd_drive_strength);
		pd_w.addr_cmd_p_predriver_code =
			pd_code(r_r.cfg.addr_cmd_drive_strength);
		if (r_r.cfg.gang4_533) begin
			pd_w.data_a_n_predriver_code = `DPCT_PD_ZERO;
			pd_w.data_a_p_predriver_code = `DPCT_PD_ZERO;
			pd_w.data_b_n_predriver_code = `DPCT_PD_ZERO;
			pd_w.data_b_p_predriver_code = `DPCT_PD_ZERO;
		end else begin
			pd_w.data_a_n_predriver_code =
				pd_code(r_r.cfg.data_drive_strength);
			pd_w.data_a_p_predriver_code =
				pd_code(r_r.cfg.data_drive_strength);
			pd_w.data_b_n_predriver_code =
				pd_code(r_r.cfg.data_drive_strength);
			pd_w.data_b_p_predriver_code =
				pd_code(r_r.cfg.data_drive_strength);
		end

		tim_w = '0;
		tim_w.read_cas = r_r.lat.read_cas;
		tim_w.write_cas = r_r.lat.write_cas;

		turn_w = '0;
		turn_w.read_read_turnaround =
			turn_calc(crit_diff(rcv_max, rcv_min), 7'sh00);
		turn_w.write_write_turnaround =
			turn_calc(crit_diff(wrd_max, wrd_min), 7'sh00);
		turn_w.write_read_turnaround =
			turn_calc(crit_diff(wrd_max, rcv_min), -ld);
		turn_w.read_write_turnaround =
			turn_calc(crit_diff(rcv_max, wrd_min), ld);

		stat_w = '0;
		stat_w.state = 4'(r_r.st);
		stat_w.pass = r_r.pass;
		stat_w.busy = r_r.busy;
		stat_w.train_wait = r_r.train_wait;
		stat_w.done = r_r.done;
		stat_w.type_bad = r_r.type_bad;
		stat_w.ddr3 = r_r.ddr3;

		// Configuration is frozen while a sequence runs
		if (sw_req.wr && !r_r.busy) begin
			case (sw_req.addr)
				`DPCT_SW_CFG: r_nxt.cfg = dpct_sw_cfg_s'(sw_req.wdata);
				`DPCT_SW_SPD: r_nxt.spd = dpct_sw_spd_s'(sw_req.wdata);
				`DPCT_SW_LAT: r_nxt.lat = dpct_lat_s'(sw_req.wdata);
				default: ;
			endcase
		end
		// Trained delays arrive while the sequencer waits for them
		if (sw_req.wr && sw_req.addr == `DPCT_SW_RCV)
			r_nxt.rcv = sw_req.wdata[NMOD*DW-1:0];
		if (sw_req.wr && sw_req.addr == `DPCT_SW_WRD)
			r_nxt.wrd = sw_req.wdata[NMOD*DW-1:0];

		// Read data last one cycle; idle cycles give zero
		r_nxt.rdata = `DPCT_W32_ZERO;
		if (sw_req.rd) begin
			case (sw_req.addr)
				`DPCT_SW_CFG:  r_nxt.rdata = 32'(r_r.cfg);
				`DPCT_SW_SPD:  r_nxt.rdata = 32'(r_r.spd);
				`DPCT_SW_LAT:  r_nxt.rdata = 32'(r_r.lat);
				`DPCT_SW_RCV:  r_nxt.rdata = 32'(r_r.rcv);
				`DPCT_SW_WRD:  r_nxt.rdata = 32'(r_r.wrd);
				`DPCT_SW_STAT: r_nxt.rdata = 32'(stat_w);
				`DPCT_SW_TURN: r_nxt.rdata = 32'(r_r.turn);
				default:       r_nxt.rdata = `DPCT_W32_ZERO;
			endcase
		end

		case (r_r.st)
			DPCT_IDLE: begin
				if (ctrl_w.start) begin
					// Type byte decides how the rest is read
					if (!is_ddr2 && !is_ddr3) begin
						r_nxt.type_bad = 1'b1;
					end else begin
						r_nxt.type_bad = 1'b0;
						r_nxt.ddr3 = is_ddr3;
						r_nxt.freq = freq_sel;
						r_nxt.two_pass = is_ddr3 &&
							freq_sel > `DPCT_FREQ_400;
						r_nxt.pass = 1'b0;
						r_nxt.done = 1'b0;
						r_nxt.busy = 1'b1;
						r_nxt.st = DPCT_MODE;
					end
				end
			end

			DPCT_MODE: begin
				// First write of every pass routes later accesses
				r_nxt.dev = dev_write(`DPCT_DEV_MODE, 32'(mode_w));
				r_nxt.st = DPCT_COMP_OFF;
			end

			DPCT_COMP_OFF: begin
				comp_w.auto_comp_disable = 1'b1;
				r_nxt.dev = dev_write(`DPCT_DEV_COMP, 32'(comp_w));
				r_nxt.wcnt = `DPCT_CNT_ZERO;
				r_nxt.st = DPCT_COMP_WAIT;
			end

			// Counts whole cycles, so the wait is never shorter than asked
			DPCT_COMP_WAIT: begin
				r_nxt.wcnt = r_r.wcnt + 16'h0001;
				if (r_r.wcnt == COMP_LAST)
					r_nxt.st = DPCT_PREDRV;
			end

			DPCT_PREDRV: begin
				// Codes land before any command leaves the controller
				r_nxt.dev = dev_write(`DPCT_DEV_PD, 32'(pd_w));
				r_nxt.st = DPCT_TIMING;
			end

			DPCT_TIMING: begin
				r_nxt.dev = dev_write(`DPCT_DEV_TIM, 32'(tim_w));
				r_nxt.st = DPCT_TURN_MAX;
			end

			// Safe gaps while the delays are still untrained
			DPCT_TURN_MAX: begin
				r_nxt.turn = '0;
				r_nxt.turn.read_read_turnaround = `DPCT_TURN_MAX;
				r_nxt.turn.write_write_turnaround = `DPCT_TURN_MAX;
				r_nxt.turn.write_read_turnaround = `DPCT_TURN_MAX;
				r_nxt.turn.read_write_turnaround = `DPCT_TURN_MAX;
				r_nxt.dev = dev_write(`DPCT_DEV_TURN,
					32'(r_nxt.turn));
				r_nxt.train_wait = 1'b1;
				r_nxt.st = DPCT_TRAIN_WAIT;
			end

			DPCT_TRAIN_WAIT: begin
				// Software trains the memory and reports the delays
				if (ctrl_w.train_done) begin
					r_nxt.train_wait = 1'b0;
					r_nxt.st = DPCT_TURN_OPT;
				end
			end

			DPCT_TURN_OPT: begin
				r_nxt.turn = turn_w;
				r_nxt.dev = dev_write(`DPCT_DEV_TURN, 32'(turn_w));
				r_nxt.st = DPCT_COMP_ON;
			end

			DPCT_COMP_ON: begin
				// Compensation returns at the end of every pass, the first of two included
				comp_w.auto_comp_disable = 1'b0;
				r_nxt.dev = dev_write(`DPCT_DEV_COMP, 32'(comp_w));
				if (r_r.two_pass && !r_r.pass) begin
					r_nxt.pass = 1'b1;
					r_nxt.st = DPCT_MODE;
				end else begin
					r_nxt.busy = 1'b0;
					r_nxt.done = 1'b1;
					r_nxt.st = DPCT_IDLE;
				end
			end

			default: begin
				r_nxt.busy = 1'b0;
				r_nxt.st = DPCT_IDLE;
			end
		endcase
	end

	// The device is trusted to hold gaps and freeze compensation itself
	always_ff @(posedge core_clk) begin
		if (reset) begin
			r_r <= '0;
			r_r.st <= DPCT_IDLE;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign sw_rdata = r_r.rdata;
	assign dev_req = r_r.dev;

endmodule

// [tb/dpct_dev_model.sv]
// Behavioural register set of the memory controller and its phy
`timescale 1ns/1ns
`include "dpct_cfg.svh"
module dpct_dev_model (
	// Clock
	input wire logic                    core_clk,
	// Device register port
	input wire dpct_pkg::dpct_dev_req_s dev_req
);
	import dpct_pkg::*;
	dpct_dev_mode_s mode_r = '0;
	dpct_dev_comp_s comp_r = '0;
	dpct_dev_pd_s   pd_r   = '0;
	dpct_lat_s      tim_r  = '0;
	dpct_turn_s     turn_r = '0;
	logic [2:0]     clk_log[$];
	int             writes = 0;
	// Every write is accepted at once; the port has no stall
	always @(posedge core_clk) begin
		if (dev_req.wr) begin
			writes <= writes + 1;
			case (dev_req.addr)
			`DPCT_DEV_MODE: begin
				mode_r <= dpct_dev_mode_s'(dev_req.wdata);
				clk_log.push_back(dev_req.wdata[4:2]);
			end
			// Phy compensation stays frozen while this bit is set
			`DPCT_DEV_COMP: comp_r <= dpct_dev_comp_s'(dev_req.wdata);
			`DPCT_DEV_PD:   pd_r <= dpct_dev_pd_s'(dev_req.wdata);
			`DPCT_DEV_TIM:  tim_r <= dpct_lat_s'(dev_req.wdata);
			`DPCT_DEV_TURN: turn_r <= dpct_turn_s'(dev_req.wdata);
			default: ;
			endcase
		end
	end
endmodule

// [tb/dpct_host_properties.sv]
// Port assertions of the bring-up sequencer
`timescale 1ns/1ns
`include "dpct_cfg.svh"
module dpct_host_chk (
	// Clock and reset
	input wire logic                    core_clk,
	input wire logic                    reset,
	// Software and device ports
	input wire dpct_pkg::dpct_sw_req_s  sw_req,
	input wire logic [31:0]             sw_rdata,
	input wire dpct_pkg::dpct_dev_req_s dev_req
);
	import dpct_pkg::*;
	localparam int WAIT_CYC = `DPCT_COMP_CYC;
	logic [15:0] since_off_r;
	logic [15:0] since_off_nxt;
	logic        mode_wr;
	logic        comp_wr;
	logic        pd_wr;
	logic        tim_wr;
	logic        turn_wr;
	assign mode_wr = dev_req.wr && dev_req.addr == `DPCT_DEV_MODE;
	assign comp_wr = dev_req.wr && dev_req.addr == `DPCT_DEV_COMP;
	assign pd_wr   = dev_req.wr && dev_req.addr == `DPCT_DEV_PD;
	assign tim_wr  = dev_req.wr && dev_req.addr == `DPCT_DEV_TIM;
	assign turn_wr = dev_req.wr && dev_req.addr == `DPCT_DEV_TURN;
	// Zero means not switched off since reset, so a code load then fails
	always_comb begin
		since_off_nxt = since_off_r;
		if (comp_wr && dev_req.wdata[0])
			since_off_nxt = 16'h0001;
		else if (since_off_r != 16'h0000 && since_off_r != 16'hFFFF)
			since_off_nxt = since_off_r + 16'h0001;
	end
	always_ff @(posedge core_clk) begin
		if (reset)
			since_off_r <= 16'h0000;
		else
			since_off_r <= since_off_nxt;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	AST_MODE_LEGACY_CLEAR: assert property (
		mode_wr |-> !dev_req.wdata[0]) else $error("legacy route set");
	AST_COMP_OFF_NEXT: assert property (
		mode_wr |=> comp_wr && dev_req.wdata[0])
		else $error("compensation not disabled after mode");
	AST_CODES_AFTER_WAIT: assert property (
		pd_wr |-> since_off_r >= WAIT_CYC) else $error("codes too early");
	AST_ADDR_CMD_BOTH: assert property (
		pd_wr |-> dev_req.wdata[2:0] == dev_req.wdata[5:3])
		else $error("address code sides differ");
	AST_DATA_FOUR: assert property (
		pd_wr |-> dev_req.wdata[8:6] == dev_req.wdata[11:9]
		&& dev_req.wdata[8:6] == dev_req.wdata[14:12]
		&& dev_req.wdata[8:6] == dev_req.wdata[17:15])
		else $error("data codes differ");
	AST_TIMING_AFTER_CODES: assert property (
		tim_wr |-> $past(pd_wr)) else $error("timing write out of order");
	AST_TURN_MAX_FIRST: assert property (
		turn_wr && $past(tim_wr) |-> dev_req.wdata[15:0] == 16'hFFFF)
		else $error("turnaround not at maximum");
	AST_COMP_ON_LAST: assert property (
		turn_wr && !$past(tim_wr) |=> comp_wr && !dev_req.wdata[0])
		else $error("compensation not re-enabled after formula");
	COV_CODES: cover property (pd_wr);
	COV_COMP_ON: cover property (comp_wr && !dev_req.wdata[0]);
	COV_READ: cover property (sw_req.rd ##1 sw_rdata != 32'h0);
endmodule
bind dpct_host dpct_host_chk i_chk (
	.core_clk(core_clk),
	.reset   (reset),
	.sw_req  (sw_req),
	.sw_rdata(sw_rdata),
	.dev_req (dev_req)
);

// [tb/test_dpct_host.sv]
// Self-checking bench of the bring-up sequencer
`timescale 1ns/1ns
`include "dpct_cfg.svh"
module test_dpct_host;
	import dpct_pkg::*;
	typedef struct {
		logic [7:0]  typ;
		logic [2:0]  tgt;
		logic [2:0]  lim;
		logic [1:0]  ac;
		logic [1:0]  da;
		logic        g;
		logic [15:0] rcv;
		logic [15:0] wrd;
		logic [4:0]  rc;
		logic [4:0]  wc;
		int          passes;
	} dpct_row_s;
	logic          core_clk = 1'b0;
	logic          reset    = 1'b1;
	dpct_sw_req_s  req      = '0;
	logic [31:0]   rdata;
	dpct_dev_req_s dev;
	logic [31:0]   st;
	int            fails        = 0;
	int            total_checks = 0;
	int            cyc          = 0;
	int            n;
	dpct_row_s     rows[4] = '{
		'{`DPCT_SPD_DDR2, 3'h3, 3'h1, 2'h0, 2'h3, 1'b0, 16'h3210, 16'h0123,
			5'h05, 5'h04, 1},
		'{`DPCT_SPD_DDR3, 3'h4, 3'h7, 2'h2, 2'h1, 1'b1, 16'h5555, 16'h2222,
			5'h07, 5'h06, 2},
		'{`DPCT_SPD_DDR3, 3'h2, 3'h5, 2'h3, 2'h2, 1'b0, 16'hF0F0, 16'h0F00,
			5'h05, 5'h08, 1},
		'{`DPCT_SPD_DDR2, 3'h6, 3'h6, 2'h1, 2'h0, 1'b1, 16'h0000, 16'h0000,
			5'h03, 5'h03, 1}
	};
	dpct_host i_dut (
		.core_clk(core_clk),
		.reset   (reset),
		.sw_req  (req),
		.sw_rdata(rdata),
		.dev_req (dev)
	);
	dpct_dev_model i_dev (
		.core_clk(core_clk),
		.dev_req (dev)
	);
	always #5 core_clk = ~core_clk;
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Whole run needs some 2700 cycles; the ceiling leaves ample margin
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
		req.addr  <= a;
		req.wdata <= d;
		req.wr    <= 1'b1;
		@(posedge core_clk);
		req.wr <= 1'b0;
		@(posedge core_clk);
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic sw_rd(input logic [7:0] a, output logic [31:0] d);
		req.addr <= a;
		req.rd   <= 1'b1;
		@(posedge core_clk);
		req.rd <= 1'b0;
		#1 d = rdata;
		@(posedge core_clk);
	endtask
	task automatic wait_bit(input int b);
		int k;
		k = 0;
		st = '0;
		while (st[b] !== 1'b1 && k < 2000) begin
			sw_rd(`DPCT_SW_STAT, st);
			k++;
		end
		chk("status bit", 32'h1, {31'h0, st[b]});
	endtask
	function automatic logic [15:0] turn_exp(input dpct_row_s r);
		int mr, nr, mw, nw, lat_diff, v[4];
		logic [15:0] o;
		mr = 0;
		nr = 15;
		mw = 0;
		nw = 15;
		for (int i = 0; i < 4; i++) begin
			mr = r.rcv[i*4+:4] > mr ? r.rcv[i*4+:4] : mr;
			nr = r.rcv[i*4+:4] < nr ? r.rcv[i*4+:4] : nr;
			mw = r.wrd[i*4+:4] > mw ? r.wrd[i*4+:4] : mw;
			nw = r.wrd[i*4+:4] < nw ? r.wrd[i*4+:4] : nw;
		end
		lat_diff = r.typ == `DPCT_SPD_DDR3 ? int'(r.rc) - int'(r.wc) : 1;
		v[0] = (mr - nr) / 2 + 3;
		v[1] = (mw - nw) / 2 + 3;
		v[2] = (mw > nr ? mw - nr : 0) / 2 - lat_diff + 3;
		v[3] = (mr > nw ? mr - nw : 0) / 2 + lat_diff + 3;
		for (int i = 0; i < 4; i++)
			o[i*4+:4] = v[i] < 0 ? 4'h0 : v[i] > 15 ? 4'hF : v[i][3:0];
		return o;
	endfunction
	task automatic run_row(input dpct_row_s r);
		logic [2:0] pc[4];
		logic [2:0] a;
		logic [2:0] d;
		logic [2:0] f;
		pc = '{`DPCT_PD_0, `DPCT_PD_1, `DPCT_PD_2, `DPCT_PD_3};
		a = pc[r.ac];
		d = r.g ? `DPCT_PD_ZERO : pc[r.da];
		f = r.tgt < r.lim ? r.tgt : r.lim;
		i_dev.clk_log.delete();
		sw_wr(`DPCT_SW_CFG, {24'h0, r.g, r.da, r.ac, r.tgt});
		sw_wr(`DPCT_SW_SPD, {21'h0, r.lim, r.typ});
		sw_wr(`DPCT_SW_LAT, {22'h0, r.wc, r.rc});
		sw_wr(`DPCT_SW_RCV, {16'h0, r.rcv});
		sw_wr(`DPCT_SW_WRD, {16'h0, r.wrd});
		sw_wr(`DPCT_SW_CTRL, 32'h1);
		for (int p = 0; p < r.passes; p++) begin
			wait_bit(6);
			chk("turn max", 32'hFFFF, i_dev.turn_r);
			chk("comp off", 32'h1, i_dev.comp_r);
			chk("codes", {14'h0, d, d, d, d, a, a}, i_dev.pd_r);
			sw_wr(`DPCT_SW_CTRL, 32'h2);
			repeat (4) @(posedge core_clk);
		end
		wait_bit(7);
		chk("turn", {16'h0, turn_exp(r)}, i_dev.turn_r);
		chk("comp on", 32'h0, i_dev.comp_r);
		chk("mode", {27'h0, f, r.typ == `DPCT_SPD_DDR3, 1'b0},
			i_dev.mode_r);
		chk("timing", {22'h0, r.wc, r.rc}, i_dev.tim_r);
		chk("passes", 32'(r.passes), 32'(i_dev.clk_log.size()));
		chk("first clock", 32'(r.passes > 1 ? `DPCT_FREQ_400 : f),
			32'(i_dev.clk_log[0]));
		$display("row done type %h clock %0d", r.typ, f);
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		sw_rd(`DPCT_SW_STAT, st);
		chk("reset status", 32'h0, st);
		$display("reset test done");
		foreach (rows[k])
			run_row(rows[k]);
		// Unknown module type must not start any device traffic
		sw_wr(`DPCT_SW_SPD, 32'h0000_0005);
		n = i_dev.writes;
		sw_wr(`DPCT_SW_CTRL, 32'h1);
		repeat (4) @(posedge core_clk);
		sw_rd(`DPCT_SW_STAT, st);
		chk("type bad", 32'h1, {31'h0, st[8]});
		chk("no device write", 32'(n), 32'(i_dev.writes));
		sw_rd(8'h20, st);
		chk("unmapped", 32'h0, st);
		$display("type and map test done");
		sw_wr(`DPCT_SW_SPD, {24'h0, `DPCT_SPD_DDR2});
		sw_wr(`DPCT_SW_CTRL, 32'h1);
		repeat (20) @(posedge core_clk);
		reset <= 1'b1;
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		sw_rd(`DPCT_SW_STAT, st);
		chk("status after reset", 32'h0, st);
		$display("mid-run reset test done");
		end_of_test();
	end
endmodule
